// >>> logic/otam_pkg.sv
// constants, register map and types for the overheat timer and alert mask block
package otam_pkg;

  localparam int unsigned REG_W = 8;

  localparam logic [7:0] ADDR_STAT1 = 8'h41;
  localparam logic [7:0] ADDR_STAT2 = 8'h42;
  localparam logic [7:0] ADDR_MASK1 = 8'h74;
  localparam logic [7:0] ADDR_MASK2 = 8'h75;
  localparam logic [7:0] ADDR_CFG3  = 8'h78;
  localparam logic [7:0] ADDR_TMR   = 8'h79;
  localparam logic [7:0] ADDR_LIMIT = 8'h7A;
  localparam logic [7:0] ADDR_CFG4  = 8'h7D;

  localparam logic [7:0] RST_MASK  = 8'h00;
  localparam logic [7:0] RST_CFG   = 8'h00;
  localparam logic [7:0] RST_LIMIT = 8'h00;
  localparam logic [7:0] RD_NONE   = 8'h00;
  localparam logic [7:0] TMR_FULL  = 8'hFF;

  // config three fields
  localparam int unsigned CFG3_P10_ALERT = 0;
  localparam int unsigned CFG3_OH_EN     = 1;
  localparam int unsigned CFG3_FULL_SPEED_ON_OVERHEAT     = 2;

  // shared pin function codes, config four bits 1:0
  localparam logic [1:0] P14_SPEED = 2'h0;
  localparam logic [1:0] P14_OH    = 2'h1;
  localparam logic [1:0] P14_ALERT = 2'h2;
  localparam logic [1:0] P14_GPIO  = 2'h3;

  // status bit positions
  localparam int unsigned ST1_SUMMARY = 7;
  localparam int unsigned ST1_P22     = 0;
  localparam int unsigned ST2_F4P     = 5;
  localparam int unsigned ST2_OVT     = 1;
  localparam int unsigned MSK1_P22    = 0;

  // timer resolution
  localparam int unsigned SYS_PERIOD_NS = 100;
  localparam int unsigned OH_LSB_NS     = 22760000;
  localparam int unsigned OH_LSB_CYCLES = OH_LSB_NS / SYS_PERIOD_NS;
  localparam int unsigned PRE_W         = 18;

  typedef enum logic [1:0] {
    OTAM_LK_IDLE = 2'b01,
    OTAM_LK_WAIT = 2'b10
  } otam_link_e;

endpackage

// >>> logic/otam_top.sv
// overheat timer, alert masking and shared pin selection with a link-clocked register port
`timescale 1ns/1ps
module otam_top #(
  parameter int unsigned OH_LSB_CYC = otam_pkg::OH_LSB_CYCLES
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  input  wire logic                        link_clk,
  input  wire logic [7:0]                  link_addr,
  input  wire logic [otam_pkg::REG_W-1:0]  link_wdata,
  input  wire logic                        link_wr,
  input  wire logic                        link_rd,
  output logic                             link_busy,
  output logic [otam_pkg::REG_W-1:0]       link_rdata,
  output logic                             link_rvalid,
  input  wire logic [6:0]                  st1_src,
  input  wire logic [7:0]                  st2_src,
  input  wire logic                        pin22_in,
  input  wire logic                        pin14_in,
  output logic                             pin14_out,
  output logic                             pin14_oe_n,
  input  wire logic                        second_fan_drive_in,
  output logic                             pin10_out,
  output logic                             pin10_oe_n,
  input  wire logic                        fan_running,
  output logic                             fan_full_speed
);
  import otam_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic [1:0] rst_sys_q;
  logic [1:0] rst_lk_q;
  logic       rst_n;
  logic       rst_lk_n;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) rst_sys_q <= 2'h0;
    else       rst_sys_q <= {rst_sys_q[0], 1'b1};
  end

  // the link side leaves reset on its own clock
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) rst_lk_q <= 2'h0;
    else       rst_lk_q <= {rst_lk_q[0], 1'b1};
  end

  assign rst_n    = rst_sys_q[1];
  assign rst_lk_n = rst_lk_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // link side: capture one request, hold it until the core acknowledges
  otam_link_e             lk_st_q;
  logic [7:0]             lk_addr_q;
  logic [REG_W-1:0]       lk_wdata_q;
  logic                   lk_wr_q;
  logic                   lk_req_q;
  logic [2:0]             lk_ack_sy_q;
  logic [REG_W-1:0]       lk_rdata_q;
  logic                   lk_rvalid_q;
  logic                   lk_take;
  logic                   lk_ack_seen;
  logic                   core_ack_q;
  logic [REG_W-1:0]       core_rdata_q;

  // a request that arrives while busy is dropped, there is no queue behind it
  assign lk_take     = (lk_st_q == OTAM_LK_IDLE) & (link_wr | link_rd);
  assign lk_ack_seen = lk_ack_sy_q[2] ^ lk_ack_sy_q[1];

  always_ff @(posedge link_clk or negedge rst_lk_n) begin
    if (!rst_lk_n) begin
      lk_ack_sy_q <= 3'h0;
    end else begin
      lk_ack_sy_q <= {lk_ack_sy_q[1:0], core_ack_q};
    end
  end

  always_ff @(posedge link_clk or negedge rst_lk_n) begin
    if (!rst_lk_n) begin
      lk_st_q     <= OTAM_LK_IDLE;
      lk_addr_q   <= 8'h00;
      lk_wdata_q  <= RD_NONE;
      lk_wr_q     <= 1'b0;
      lk_req_q    <= 1'b0;
      lk_rdata_q  <= RD_NONE;
      lk_rvalid_q <= 1'b0;
    end else begin
      lk_rvalid_q <= 1'b0;
      case (lk_st_q)
        OTAM_LK_IDLE: begin
          if (lk_take) begin
            lk_addr_q  <= link_addr;
            lk_wdata_q <= link_wdata;
            lk_wr_q    <= link_wr;
            lk_req_q   <= ~lk_req_q;
            lk_st_q    <= OTAM_LK_WAIT;
          end
        end
        OTAM_LK_WAIT: begin
          if (lk_ack_seen) begin
            // core data has stood stable since the sys_clk edge that toggled the ack
            if (!lk_wr_q) lk_rdata_q <= core_rdata_q;
            lk_rvalid_q <= ~lk_wr_q;
            lk_st_q     <= OTAM_LK_IDLE;
          end
        end
        default: lk_st_q <= OTAM_LK_IDLE;
      endcase
    end
  end

  assign link_busy   = (lk_st_q != OTAM_LK_IDLE);
  assign link_rdata  = lk_rdata_q;
  assign link_rvalid = lk_rvalid_q;

  ////////////////////////////////////////////////////////////////////////////
  // core side of the request handshake
  logic [2:0] req_sy_q;
  logic       acc_stb;
  logic       acc_wr;
  logic       acc_rd;

  // toggle crossing: one edge per request, whatever the two clock rates
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) req_sy_q <= 3'h0;
    else        req_sy_q <= {req_sy_q[1:0], lk_req_q};
  end

  // address and data held by the link until the ack returns
  assign acc_stb = req_sy_q[2] ^ req_sy_q[1];
  assign acc_wr  = acc_stb & lk_wr_q;
  assign acc_rd  = acc_stb & ~lk_wr_q;

  logic hit_st1;
  logic hit_st2;
  logic hit_mask1;
  logic hit_mask2;
  logic hit_cfg3;
  logic hit_tmr;
  logic hit_limit;
  logic hit_cfg4;

  assign hit_st1   = (lk_addr_q == ADDR_STAT1);
  assign hit_st2   = (lk_addr_q == ADDR_STAT2);
  assign hit_mask1 = (lk_addr_q == ADDR_MASK1);
  assign hit_mask2 = (lk_addr_q == ADDR_MASK2);
  assign hit_cfg3  = (lk_addr_q == ADDR_CFG3);
  assign hit_tmr   = (lk_addr_q == ADDR_TMR);
  assign hit_limit = (lk_addr_q == ADDR_LIMIT);
  assign hit_cfg4  = (lk_addr_q == ADDR_CFG4);

  ////////////////////////////////////////////////////////////////////////////
  // writable registers
  logic [REG_W-1:0] mask1_q;
  logic [REG_W-1:0] mask2_q;
  logic [REG_W-1:0] cfg3_q;
  logic [REG_W-1:0] limit_q;
  logic [REG_W-1:0] cfg4_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask1_q <= RST_MASK;
      mask2_q <= RST_MASK;
      cfg3_q  <= RST_CFG;
      limit_q <= RST_LIMIT;
      cfg4_q  <= RST_CFG;
    end else if (acc_wr) begin
      if (hit_mask1) mask1_q <= lk_wdata_q;
      if (hit_mask2) mask2_q <= lk_wdata_q;
      if (hit_cfg3)  cfg3_q  <= lk_wdata_q;
      if (hit_limit) limit_q <= lk_wdata_q;
      if (hit_cfg4)  cfg4_q  <= lk_wdata_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin inputs and function selection
  logic [1:0] p22_sy_q;
  logic [1:0] p14_sy_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // pins idle high on their pull-ups, so no false assertion after reset
      p22_sy_q <= 2'h3;
      p14_sy_q <= 2'h3;
    end else begin
      p22_sy_q <= {p22_sy_q[0], pin22_in};
      p14_sy_q <= {p14_sy_q[0], pin14_in};
    end
  end

  logic       oh_en;
  logic [1:0] p14_fn;
  logic       p14_oh;
  logic       p22_act;
  logic       p14_act;
  logic       oh_active;

  assign oh_en     = cfg3_q[CFG3_OH_EN];
  assign p14_fn    = cfg4_q[1:0];
  assign p14_oh    = oh_en & (p14_fn == P14_OH);
  assign p22_act   = oh_en & ~p22_sy_q[1];
  assign p14_act   = p14_oh & ~p14_sy_q[1];
  assign oh_active = p22_act | p14_act;

  ////////////////////////////////////////////////////////////////////////////
  // cumulative assertion timer
  logic [PRE_W-1:0] pre_q;
  logic [7:0]       tick_q;
  logic             seen_q;
  logic             rd_tmr;
  logic             tmr_sat;
  logic             pre_wrap;
  logic [7:0]       tmr_val;

  assign rd_tmr   = acc_rd & hit_tmr;
  assign tmr_sat  = (tick_q == TMR_FULL);
  assign pre_wrap = (pre_q == PRE_W'(OH_LSB_CYC - 1));
  // before the first full count, bit 0 alone marks that an assertion happened
  assign tmr_val  = (tick_q == 8'h00) ? {7'h00, seen_q} : tick_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q  <= '0;
      tick_q <= 8'h00;
      seen_q <= 1'b0;
    end else if (rd_tmr) begin
      // a read restarts the prescaler, so the next count is a whole period
      pre_q  <= '0;
      tick_q <= 8'h00;
      seen_q <= oh_active;
    end else if (oh_active && !tmr_sat) begin
      seen_q <= 1'b1;
      if (pre_wrap) begin
        pre_q  <= '0;
        tick_q <= tick_q + 8'h01;
      end else begin
        pre_q <= pre_q + PRE_W'(1);
      end
    end
  end

  logic exceed;
  logic reflag;
  logic oh_evt;

  assign exceed = (tmr_val > limit_q);
  assign reflag = rd_tmr & oh_active & (limit_q == RST_LIMIT);
  assign oh_evt = exceed | reflag;

  ////////////////////////////////////////////////////////////////////////////
  // sticky status except the live overtemperature bit, set beats a clearing read
  logic [6:0] st1_q;
  logic [7:0] st2_q;
  logic [6:0] st1_set;
  logic [7:0] st2_set;
  logic       f4p_src;
  logic       rd_st1;
  logic       rd_st2;
  logic       p14_is_speed;
  logic       p14_is_gpio;
  logic [6:0] st1_keep;
  logic [7:0] st2_keep;

  assign rd_st1 = acc_rd & hit_st1;
  assign rd_st2 = acc_rd & hit_st2;
  assign p14_is_speed = (p14_fn == P14_SPEED);
  assign p14_is_gpio  = (p14_fn == P14_GPIO);
  assign st1_keep = st1_q & ~{7{rd_st1}};
  // overtemperature is live, never held, so it drops out of the kept bits
  assign st2_keep = st2_q & ~{8{rd_st2}} & ~(8'h01 << ST2_OVT);

  // shared pin source for status two bit 5
  assign f4p_src = oh_evt
                 | (p14_is_speed & st2_src[ST2_F4P])
                 | (p14_is_gpio & ~p14_sy_q[1]);

  assign st1_set = {st1_src[6:1], oh_en ? oh_evt : st1_src[ST1_P22]};
  assign st2_set = {st2_src[7:6], f4p_src, st2_src[4:0]};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) st1_q <= 7'h00;
    else        st1_q <= st1_set | st1_keep;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) st2_q <= 8'h00;
    else        st2_q <= st2_set | st2_keep;
  end

  logic [7:0] st1_view;
  assign st1_view = {|st2_q, st1_q};

  ////////////////////////////////////////////////////////////////////////////
  // alert generation
  logic [7:0] mask2_eff;
  logic       any1;
  logic       any2;
  logic       alert;
  logic       p10_alert;
  logic       p14_alert;

  // with only pin 22 timing, the bank-one 2.5 V mask also hides the timer flag
  assign mask2_eff = {mask2_q[7:6],
                      mask2_q[ST2_F4P] | (oh_en & ~p14_oh & mask1_q[MSK1_P22]),
                      mask2_q[4:0]};
  assign any1  = |(st1_q & ~mask1_q[6:0]);
  assign any2  = ~mask1_q[ST1_SUMMARY] & |(st2_q & ~mask2_eff);
  assign alert = any1 | any2;

  // pin 10 stays the fan drive until the alert is chosen for it
  assign p10_alert = cfg3_q[CFG3_P10_ALERT];
  assign p14_alert = (p14_fn == P14_ALERT);

  logic p10_out_q;
  logic p10_oe_n_q;
  logic p14_oe_n_q;
  logic full_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      p10_out_q  <= 1'b0;
      p10_oe_n_q <= 1'b0;
    end else begin
      p10_out_q  <= p10_alert ? 1'b0 : second_fan_drive_in;
      p10_oe_n_q <= p10_alert ? ~alert : 1'b0;
    end
  end

  // pin 14 only pulls low; the board pull-up gives the released level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) p14_oe_n_q <= 1'b1;
    else        p14_oe_n_q <= ~(p14_alert & alert);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) full_q <= 1'b0;
    else        full_q <= cfg3_q[CFG3_FULL_SPEED_ON_OVERHEAT] & oh_active & fan_running;
  end

  assign pin10_out      = p10_out_q;
  assign pin10_oe_n     = p10_oe_n_q;
  assign pin14_out      = 1'b0;
  assign pin14_oe_n     = p14_oe_n_q;
  assign fan_full_speed = full_q;

  ////////////////////////////////////////////////////////////////////////////
  // read data and acknowledge back to the link
  logic [REG_W-1:0] rd_mux;

  // unmapped addresses read as zero
  assign rd_mux = hit_st1   ? st1_view :
                  hit_st2   ? st2_q    :
                  hit_mask1 ? mask1_q  :
                  hit_mask2 ? mask2_q  :
                  hit_cfg3  ? cfg3_q   :
                  hit_tmr   ? tmr_val  :
                  hit_limit ? limit_q  :
                  hit_cfg4  ? cfg4_q   : RD_NONE;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_rdata_q <= RD_NONE;
      core_ack_q   <= 1'b0;
    end else if (acc_stb) begin
      core_rdata_q <= rd_mux;
      core_ack_q   <= ~core_ack_q;
    end
  end

endmodule // otam_top

// >>> tb/otam_properties.sv
// concurrent checks on the overheat timer block ports
`timescale 1ns/1ps
module otam_properties (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       link_clk,
  input wire logic       link_wr,
  input wire logic       link_rd,
  input wire logic       link_busy,
  input wire logic       link_rvalid,
  input wire logic [7:0] st2_src,
  input wire logic       pin22_in,
  input wire logic       pin14_in,
  input wire logic       pin14_out,
  input wire logic       pin14_oe_n,
  input wire logic       second_fan_drive_in,
  input wire logic       pin10_out,
  input wire logic       pin10_oe_n,
  input wire logic       fan_running,
  input wire logic       fan_full_speed
);
  logic [3:0] oh_hist_q;
  logic [3:0] ovt_hist_q;
  logic [3:0] quiet_q;

  // histories span the 3-cycle pin latency plus one of slack
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      oh_hist_q  <= 4'h0;
      ovt_hist_q <= 4'h0;
      quiet_q    <= 4'hF;
    end else begin
      oh_hist_q  <= {oh_hist_q[2:0], ~(pin22_in & pin14_in)};
      ovt_hist_q <= {ovt_hist_q[2:0], st2_src[1]};
      quiet_q    <= link_busy ? 4'h0 : ((quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  sequence s_req_taken;
    (link_wr || link_rd) && !link_busy;
  endsequence

  a_alert_off_reset: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(rstn) |-> ##1 (pin14_oe_n && !pin10_oe_n)[*2]) else $error("alert pins busy after reset");
  a_fan_drive_follow: assert property (@(posedge sys_clk) disable iff (!rstn)
    pin10_out |-> $past(second_fan_drive_in)) else $error("pin 10 high without fan drive");
  a_full_speed_on_overheat_has_cause: assert property (@(posedge sys_clk) disable iff (!rstn)
    fan_full_speed |-> (oh_hist_q != 4'h0)) else $error("full speed without overheat");
  a_full_speed_on_overheat_needs_run: assert property (@(posedge sys_clk) disable iff (!rstn)
    fan_full_speed |-> (fan_running || $past(fan_running) || $past(fan_running, 2)))
    else $error("full speed on stopped fans");
  a_shared_pin_od: assert property (@(posedge sys_clk) disable iff (!rstn)
    pin14_out == 1'h0) else $error("shared pin driven high");
  a_alert10_held: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(pin10_oe_n) |-> (quiet_q < 4'h8) || (ovt_hist_q != 4'h0))
    else $error("pin 10 alert released without access");
  a_alert14_held: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(pin14_oe_n) |-> (quiet_q < 4'h8) || (ovt_hist_q != 4'h0))
    else $error("pin 14 alert released without access");
  a_busy_bounded: assert property (@(posedge link_clk) disable iff (!rstn)
    s_req_taken |=> link_busy ##[1:40] !link_busy) else $error("register access hung");
  a_rvalid_single: assert property (@(posedge link_clk) disable iff (!rstn)
    link_rvalid |-> !link_busy ##1 !link_rvalid) else $error("read valid malformed");
endmodule // otam_properties

bind otam_top otam_properties u_props (.sys_clk(sys_clk), .rstn(rstn), .link_clk(link_clk),
  .link_wr(link_wr), .link_rd(link_rd), .link_busy(link_busy), .link_rvalid(link_rvalid),
  .st2_src(st2_src), .pin22_in(pin22_in), .pin14_in(pin14_in), .pin14_out(pin14_out),
  .pin14_oe_n(pin14_oe_n), .second_fan_drive_in(second_fan_drive_in), .pin10_out(pin10_out),
  .pin10_oe_n(pin10_oe_n), .fan_running(fan_running), .fan_full_speed(fan_full_speed));

// >>> tb/otam_hot_src.sv
// overheat source and open-drain wiring of pins 22 and 14
`timescale 1ns/1ps
module otam_hot_src (
  input  wire logic hot22,
  input  wire logic hot14,
  input  wire logic pin14_out,
  input  wire logic pin14_oe_n,
  output logic      pin22_in,
  output logic      pin14_in
);
  // both lines have pull-ups, so a released line reads high
  assign pin22_in = ~hot22;
  assign pin14_in = ~(hot14 | (~pin14_oe_n & ~pin14_out));
endmodule // otam_hot_src

// >>> tb/otam_top_tb.sv
// self-checking bench for the overheat timer and alert mask block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module otam_top_tb;
  import otam_pkg::*;
  logic       sys_clk, rstn, link_clk, link_wr, link_rd, link_busy, link_rvalid;
  logic [7:0] link_addr, link_wdata, link_rdata, st2_src, rd_q;
  logic [6:0] st1_src;
  logic       pin22_in, pin14_in, pin14_out, pin14_oe_n, second_fan_drive_in, pin10_out, pin10_oe_n;
  logic       fan_running, fan_full_speed, hot22, hot14;
  logic [7:0] addrs [7] = '{8'h74, 8'h75, 8'h78, 8'h79, 8'h7A, 8'h7D, 8'h10};
  int         mismatches, n_compared, cycles;

  otam_top #(.OH_LSB_CYC(8)) DUT (.sys_clk(sys_clk), .rstn(rstn), .link_clk(link_clk),
    .link_addr(link_addr), .link_wdata(link_wdata), .link_wr(link_wr), .link_rd(link_rd),
    .link_busy(link_busy), .link_rdata(link_rdata), .link_rvalid(link_rvalid),
    .st1_src(st1_src), .st2_src(st2_src), .pin22_in(pin22_in), .pin14_in(pin14_in),
    .pin14_out(pin14_out), .pin14_oe_n(pin14_oe_n), .second_fan_drive_in(second_fan_drive_in),
    .pin10_out(pin10_out), .pin10_oe_n(pin10_oe_n), .fan_running(fan_running),
    .fan_full_speed(fan_full_speed));
  otam_hot_src HOT (.hot22(hot22), .hot14(hot14), .pin14_out(pin14_out),
    .pin14_oe_n(pin14_oe_n), .pin22_in(pin22_in), .pin14_in(pin14_in));

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'h0;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  // fan drive toggles so the pin 10 path is exercised; run length capped
  always @(negedge sys_clk) begin
    second_fan_drive_in <= (second_fan_drive_in === 1'h1) ? 1'h0 : 1'h1;
    cycles++;
    if (cycles > 6000) begin
      mismatches++;
      stop_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // request held over the taking edge, then released; wait bounded on busy
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(negedge link_clk);
    link_wr = w;
    link_rd = ~w;
    link_addr = a;
    link_wdata = d;
    @(negedge link_clk);
    link_wr = 1'h0;
    link_rd = 1'h0;
    n = 0;
    while (link_busy !== 1'h0 && n < 60) begin
      @(negedge link_clk);
      n++;
    end
    `CHK("link_busy", 1'h0, link_busy)
    `CHK("link_rvalid", ~w, link_rvalid)
    rd_q = link_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'h1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    xfer(1'h0, a, 8'h00);
    `CHK("read data", e, rd_q)
  endtask
  task automatic oh(input logic l22, input logic l14, input int n);
    @(negedge sys_clk);
    hot22 = l22;
    hot14 = l14;
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic hot(input logic on14, input int n);
    oh(~on14, on14, n);
    oh(1'h0, 1'h0, 6);
  endtask
  // timer first so the exceed condition is gone before status reads
  task automatic clr;
    xfer(1'h0, 8'h79, 8'h00);
    xfer(1'h0, 8'h42, 8'h00);
    xfer(1'h0, 8'h41, 8'h00);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, link_wr, link_rd, link_addr, link_wdata, st1_src, st2_src} = '0;
    {second_fan_drive_in, fan_running, hot22, hot14, mismatches, n_compared, cycles} = '0;
    repeat (4) @(negedge sys_clk);
    rstn = 1'h1;
    repeat (4) @(negedge sys_clk);
    `CHK("pin10_oe_n", 1'h0, pin10_oe_n)
    `CHK("pin14_oe_n", 1'h1, pin14_oe_n)
    foreach (addrs[i]) rdc(addrs[i], 8'h00);
    wr(8'h74, 8'hA5);
    rdc(8'h74, 8'hA5);
    wr(8'h75, 8'h5A);
    rdc(8'h75, 8'h5A);
    wr(8'h10, 8'hFF);
    rdc(8'h10, 8'h00);
    wr(8'h74, 8'h00);
    wr(8'h75, 8'h00);
    hot(1'h0, 20);
    rdc(8'h79, 8'h00);
    $display("test reset and registers done");
    wr(8'h78, 8'h02);
    hot(1'h0, 4);
    rdc(8'h79, 8'h01);
    rdc(8'h79, 8'h00);
    hot(1'h0, 14);
    hot(1'h0, 14);
    rdc(8'h79, 8'h03);
    oh(1'h1, 1'h0, 2100);
    rdc(8'h79, 8'hFF);
    oh(1'h1, 1'h0, 2);
    oh(1'h0, 1'h0, 6);
    rdc(8'h79, 8'h01);
    rdc(8'h42, 8'h20);
    clr();
    $display("test timer done");
    wr(8'h78, 8'h03);
    repeat (2) @(negedge sys_clk);
    `CHK("pin10_oe_n", 1'h1, pin10_oe_n)
    hot(1'h0, 4);
    `CHK("pin10_oe_n", 1'h0, pin10_oe_n)
    rdc(8'h42, 8'h20);
    clr();
    repeat (4) @(negedge sys_clk);
    `CHK("pin10_oe_n", 1'h1, pin10_oe_n)
    wr(8'h75, 8'h20);
    wr(8'h74, 8'h01);
    wr(8'h7A, 8'h01);
    hot(1'h0, 4);
    rdc(8'h42, 8'h00);
    hot(1'h0, 16);
    `CHK("pin10_oe_n", 1'h1, pin10_oe_n)
    rdc(8'h42, 8'h20);
    clr();
    wr(8'h74, 8'h00);
    wr(8'h75, 8'h00);
    wr(8'h7A, 8'h00);
    $display("test limit and masks done");
    wr(8'h78, 8'h02);
    wr(8'h7D, 8'h02);
    @(negedge sys_clk);
    st2_src = 8'h04;
    repeat (4) @(negedge sys_clk);
    `CHK("pin14_oe_n", 1'h0, pin14_oe_n)
    rdc(8'h42, 8'h04);
    @(negedge sys_clk);
    st2_src = 8'h00;
    rdc(8'h42, 8'h04);
    rdc(8'h42, 8'h00);
    repeat (2) @(negedge sys_clk);
    `CHK("pin14_oe_n", 1'h1, pin14_oe_n)
    wr(8'h7D, 8'h01);
    wr(8'h78, 8'h00);
    hot(1'h1, 10);
    rdc(8'h79, 8'h00);
    wr(8'h78, 8'h02);
    hot(1'h1, 10);
    rdc(8'h79, 8'h01);
    clr();
    wr(8'h7D, 8'h03);
    hot(1'h1, 4);
    rdc(8'h42, 8'h20);
    wr(8'h7D, 8'h00);
    $display("test shared pin done");
    wr(8'h78, 8'h06);
    fan_running = 1'h1;
    oh(1'h1, 1'h0, 6);
    `CHK("fan_full_speed", 1'h1, fan_full_speed)
    fan_running = 1'h0;
    repeat (4) @(negedge sys_clk);
    `CHK("fan_full_speed", 1'h0, fan_full_speed)
    fan_running = 1'h1;
    wr(8'h78, 8'h02);
    repeat (4) @(negedge sys_clk);
    `CHK("fan_full_speed", 1'h0, fan_full_speed)
    oh(1'h0, 1'h0, 6);
    clr();
    $display("test full_speed_on_overheat done");
    stop_test();
  end
endmodule // otam_top_tb
